/* File: logic/pcw_regs.sv */
// PLL2 calibration wait registers, calibration timing sequencer, and
// NVM stored CRC, live CRC and program-cycle count bookkeeping.
// Assumes an NVM engine that streams bytes between start and end pulses,
// and a register port driven by the serial management slave.
`timescale 1ns/1ps
`default_nettype none

module pcw_regs
  import pcw_pkg::*;
#(
  parameter int unsigned CLSD0_CYC = PCW_CLSD0_CYC,
  parameter int unsigned CLSD1_CYC = PCW_CLSD1_CYC,
  parameter int unsigned CLSD2_CYC = PCW_CLSD2_CYC,
  parameter int unsigned CLSD3_CYC = PCW_CLSD3_CYC,
  parameter int unsigned OSC0_CYC = PCW_OSC0_CYC,
  parameter int unsigned OSC1_CYC = PCW_OSC1_CYC,
  parameter int unsigned OSC2_CYC = PCW_OSC2_CYC,
  parameter int unsigned OSC3_CYC = PCW_OSC3_CYC,
  parameter int unsigned CALDLY_CYC = PCW_CALDLY_CYC,
  parameter logic [7:0] CRC_POLY = PCW_CRC_POLY,
  parameter logic [7:0] CRC_INIT = PCW_CRC_INIT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cal_start,
  output logic osc_cal_start,
  output logic cal_busy,
  output logic cal_done,
  input wire logic nvm_rd_start,
  input wire pcw_nvm_byte_t nvm_rd_byte,
  input wire logic nvm_rd_end,
  input wire logic nvm_pg_start,
  input wire pcw_nvm_byte_t nvm_pg_byte,
  input wire logic nvm_pg_end,
  output logic [7:0] pg_count,
  output logic [7:0] stored_crc_byte,
  output logic crc_error_flag
);

  // ==========================================================================
  // Register file.
  logic [1:0] closed_loop_wait_sel_q;
  logic [1:0] osc_settle_wait_sel_q;
  logic cal_start_delay_en_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_wait_w;
  logic wr_delay_w;

  // Write decode; read-only offsets ignore writes.
  assign wr_wait_w = ce && reg_wr && (reg_addr == PCW_OFS_CAL_WAIT);
  assign wr_delay_w = ce && reg_wr && (reg_addr == PCW_OFS_CAL_DELAY);

  // Writable control fields; oscillator wait resets to its recommended code.
  // control field reset and write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      closed_loop_wait_sel_q <= PCW_CLSD_RST;
      osc_settle_wait_sel_q <= PCW_OSC_RST;
      cal_start_delay_en_q <= PCW_DLY_RST;
    end else begin
      if (wr_wait_w) begin
        closed_loop_wait_sel_q <= reg_wdata[PCW_CLSD_LSB +: 2];
        osc_settle_wait_sel_q <= reg_wdata[PCW_OSC_LSB +: 2];
      end
      if (wr_delay_w) begin
        cal_start_delay_en_q <= reg_wdata[PCW_DLY_BIT];
      end
    end
  end

  // ==========================================================================
  // Calibration sequencer: optional start delay, oscillator wait, then
  // closed-loop wait.
  pcw_cal_state_t state_q;
  pcw_cal_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] osc_load_w;
  logic [31:0] clsd_load_w;
  logic [31:0] dly_load_w;
  logic cnt_zero_w;
  logic osc_go_d;
  logic done_d;
  logic osc_go_q;
  logic done_q;

  assign clsd_load_w = (closed_loop_wait_sel_q == 2'h0) ? 32'(CLSD0_CYC - 1) :
                       (closed_loop_wait_sel_q == 2'h1) ? 32'(CLSD1_CYC - 1) :
                       (closed_loop_wait_sel_q == 2'h2) ? 32'(CLSD2_CYC - 1) :
                       32'(CLSD3_CYC - 1);
  assign osc_load_w = (osc_settle_wait_sel_q == 2'h0) ? 32'(OSC0_CYC - 1) :
                      (osc_settle_wait_sel_q == 2'h1) ? 32'(OSC1_CYC - 1) :
                      (osc_settle_wait_sel_q == 2'h2) ? 32'(OSC2_CYC - 1) :
                      32'(OSC3_CYC - 1);
  assign dly_load_w = 32'(CALDLY_CYC - 1);
  assign cnt_zero_w = (cnt_q == 32'h0000_0000);
  // Next state; a start request while busy is ignored.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero_w ? cnt_q : cnt_q - 32'h0000_0001;
    osc_go_d = 1'b0;
    done_d = 1'b0;
    unique case (state_q)
      PCW_CAL_IDLE: begin
        if (cal_start) begin
          if (cal_start_delay_en_q) begin
            state_d = PCW_CAL_DELAY;
            cnt_d = dly_load_w;
          end else begin
            state_d = PCW_CAL_OSC;
            cnt_d = osc_load_w;
            osc_go_d = 1'b1;
          end
        end
      end
      PCW_CAL_DELAY: begin
        if (cnt_zero_w) begin
          state_d = PCW_CAL_OSC;
          cnt_d = osc_load_w;
          osc_go_d = 1'b1;
        end
      end
      PCW_CAL_OSC: begin
        if (cnt_zero_w) begin
          state_d = PCW_CAL_CLOSED;
          cnt_d = clsd_load_w;
        end
      end
      PCW_CAL_CLOSED: begin
        if (cnt_zero_w) begin
          state_d = PCW_CAL_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PCW_CAL_IDLE;
      cnt_q <= 32'h0000_0000;
      osc_go_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      osc_go_q <= osc_go_d;
      done_q <= done_d;
    end
  end
  assign osc_cal_start = osc_go_q;
  assign cal_done = done_q;
  assign cal_busy = (state_q != PCW_CAL_IDLE);

  // ==========================================================================
  // NVM bookkeeping: one CRC engine for both programming and read-back.
  logic [7:0] crc_w;
  logic crc_clear_w;
  logic crc_feed_w;
  logic [7:0] crc_data_w;
  logic [7:0] count_q;
  logic [7:0] pg_count_q;
  logic [7:0] stored_crc_q;
  logic [7:0] live_crc_q;
  logic crc_err_q;
  logic [7:0] count_inc_w;

  assign crc_clear_w = nvm_rd_start || nvm_pg_start;
  assign crc_feed_w = (nvm_rd_byte.valid && !nvm_rd_byte.is_crc) ||
                      (nvm_pg_byte.valid && !nvm_pg_byte.is_crc);
  assign crc_data_w = nvm_rd_byte.valid ? nvm_rd_byte.data : nvm_pg_byte.data;
  assign count_inc_w = (count_q == PCW_COUNT_MAX) ? count_q
                                                  : count_q + 8'h01;
  pcw_crc8 #(
    .POLY(CRC_POLY),
    .INIT(CRC_INIT)
  ) u_crc (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .clear(crc_clear_w),
    .feed(crc_feed_w),
    .data(crc_data_w),
    .crc(crc_w)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= PCW_BYTE_RST;
      pg_count_q <= PCW_BYTE_RST;
    end else if (ce) begin
      if (nvm_pg_start) begin
        pg_count_q <= count_inc_w;
      end
      if (nvm_rd_byte.valid && nvm_rd_byte.is_count) begin
        count_q <= nvm_rd_byte.data;
      end else if (nvm_pg_end) begin
        count_q <= pg_count_q;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stored_crc_q <= PCW_BYTE_RST;
      live_crc_q <= PCW_BYTE_RST;
      crc_err_q <= 1'b0;
    end else if (ce) begin
      if (nvm_pg_end) begin
        stored_crc_q <= crc_w;
      end else if (nvm_rd_byte.valid && nvm_rd_byte.is_crc) begin
        stored_crc_q <= nvm_rd_byte.data;
      end
      if (nvm_rd_end) begin
        live_crc_q <= crc_w;
        crc_err_q <= (crc_w != stored_crc_q);
      end else if (nvm_rd_start) begin
        crc_err_q <= 1'b0;
      end
    end
  end
  assign pg_count = pg_count_q;
  assign stored_crc_byte = stored_crc_q;
  assign crc_error_flag = crc_err_q;

  // ==========================================================================
  // Read mux; reserved bits and unmapped offsets read zero.
  assign rdata_d =
    (reg_addr == PCW_OFS_CAL_WAIT) ? {4'h0, closed_loop_wait_sel_q,
                                      osc_settle_wait_sel_q} :
    (reg_addr == PCW_OFS_CAL_DELAY) ? {7'h00, cal_start_delay_en_q} :
    (reg_addr == PCW_OFS_STORED_CRC) ? stored_crc_q :
    (reg_addr == PCW_OFS_PROG_COUNT) ? count_q :
    (reg_addr == PCW_OFS_NVM_CTRL) ? (8'(crc_err_q) << PCW_CRCERR_BIT) :
    (reg_addr == PCW_OFS_LIVE_CRC) ? live_crc_q : 8'h00;

  // Read data register, loaded on a read strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================================
  // Assertions.
  sequence s_enter_osc;
    (state_q == PCW_CAL_OSC) && ($past(state_q) != PCW_CAL_OSC);
  endsequence
  sequence s_enter_closed;
    (state_q == PCW_CAL_CLOSED) && ($past(state_q) != PCW_CAL_CLOSED);
  endsequence
  a_osc_wait_len: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_enter_osc |-> (cnt_q == $past(osc_load_w)) && osc_cal_start)
    else $error("Oscillator wait loaded with wrong length.");
  a_closed_wait_len: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_enter_closed |-> (cnt_q == $past(clsd_load_w)))
    else $error("Closed-loop wait loaded with wrong length.");
  a_delay_taken: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && cal_start && state_q == PCW_CAL_IDLE && cal_start_delay_en_q)
    |=> (state_q == PCW_CAL_DELAY) && (cnt_q == dly_load_w) && !osc_cal_start)
    else $error("Calibration delay not applied.");
  a_delay_skipped: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && cal_start && state_q == PCW_CAL_IDLE && !cal_start_delay_en_q)
    |=> (state_q == PCW_CAL_OSC) && osc_cal_start)
    else $error("Oscillator calibration delayed without request.");
  a_count_sat: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && nvm_pg_start && count_q == PCW_COUNT_MAX) |=>
    (pg_count_q == PCW_COUNT_MAX))
    else $error("Program count wrapped past its maximum.");
  a_count_inc: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && nvm_pg_end && !(nvm_rd_byte.valid && nvm_rd_byte.is_count)) |=>
    (count_q == $past(pg_count_q)))
    else $error("Program count not advanced after program cycle.");
  a_count_reload: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && nvm_rd_byte.valid && nvm_rd_byte.is_count) |=>
    (count_q == $past(nvm_rd_byte.data)))
    else $error("Program count not reloaded from memory.");
  a_stored_crc: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && nvm_pg_end) |=> (stored_crc_byte == $past(crc_w)))
    else $error("Stored CRC not taken at end of programming.");
  a_crc_skip: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && !crc_clear_w && nvm_rd_byte.valid && nvm_rd_byte.is_crc)
    |=> $stable(crc_w))
    else $error("Stored CRC byte entered the live CRC.");
  a_crc_error: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ce && nvm_rd_end) |=> (crc_error_flag == ($past(crc_w) !=
                                               $past(stored_crc_q)))
      && (live_crc_q == $past(crc_w)))
    else $error("CRC error flag or live CRC wrong after read-back.");

endmodule

`default_nettype wire

/* File: shared/pcw_pkg.sv */
// Package for the PLL2 calibration wait and NVM CRC/count register block.
// Assumes a 250 MHz block clock that also times the calibration waits.
`default_nettype none

package pcw_pkg;

  // ==========================================================================
  // Register offsets on the internal register port.
  localparam logic [7:0] PCW_OFS_CAL_WAIT = 8'h85;
  localparam logic [7:0] PCW_OFS_CAL_DELAY = 8'h86;
  localparam logic [7:0] PCW_OFS_STORED_CRC = 8'h87;
  localparam logic [7:0] PCW_OFS_PROG_COUNT = 8'h88;
  localparam logic [7:0] PCW_OFS_NVM_CTRL = 8'h89;
  localparam logic [7:0] PCW_OFS_LIVE_CRC = 8'h8A;

  // ==========================================================================
  // Field positions and reset values.
  localparam int PCW_CLSD_LSB = 2;
  localparam int PCW_OSC_LSB = 0;
  localparam int PCW_DLY_BIT = 0;
  localparam int PCW_CRCERR_BIT = 5;
  localparam logic [1:0] PCW_CLSD_RST = 2'h0;
  localparam logic [1:0] PCW_OSC_RST = 2'h1;
  localparam logic PCW_DLY_RST = 1'b0;
  localparam logic [7:0] PCW_BYTE_RST = 8'h00;
  localparam logic [7:0] PCW_COUNT_MAX = 8'hFF;

  // ==========================================================================
  // Wait times in microseconds and their counts in clock cycles.
  localparam int unsigned PCW_CLK_MHZ = 250;
  localparam int unsigned PCW_CLSD0_US = 30;
  localparam int unsigned PCW_CLSD1_US = 300;
  localparam int unsigned PCW_CLSD2_US = 30000;
  localparam int unsigned PCW_CLSD3_US = 300000;
  localparam int unsigned PCW_OSC0_US = 20;
  localparam int unsigned PCW_OSC1_US = 400;
  localparam int unsigned PCW_OSC2_US = 8000;
  localparam int unsigned PCW_OSC3_US = 200000;
  localparam int unsigned PCW_CALDLY_US = 60000;
  localparam int unsigned PCW_CLSD0_CYC = PCW_CLSD0_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_CLSD1_CYC = PCW_CLSD1_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_CLSD2_CYC = PCW_CLSD2_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_CLSD3_CYC = PCW_CLSD3_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_OSC0_CYC = PCW_OSC0_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_OSC1_CYC = PCW_OSC1_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_OSC2_CYC = PCW_OSC2_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_OSC3_CYC = PCW_OSC3_US * PCW_CLK_MHZ;
  localparam int unsigned PCW_CALDLY_CYC = PCW_CALDLY_US * PCW_CLK_MHZ;

  // ==========================================================================
  // CRC engine defaults.
  localparam logic [7:0] PCW_CRC_POLY = 8'h07;
  localparam logic [7:0] PCW_CRC_INIT = 8'h00;

  // One byte streamed by the NVM engine.
  typedef struct packed {
    logic valid;
    logic is_crc;
    logic is_count;
    logic [7:0] data;
  } pcw_nvm_byte_t;

  // Calibration sequencer states.
  typedef enum logic [1:0] {
    PCW_CAL_IDLE = 2'b00,
    PCW_CAL_DELAY = 2'b01,
    PCW_CAL_OSC = 2'b10,
    PCW_CAL_CLOSED = 2'b11
  } pcw_cal_state_t;

endpackage

`default_nettype wire

/* File: logic/pcw_crc8.sv */
// Eight-bit CRC engine, one byte per enabled cycle, MSB first.
// Assumes the caller clears it before each byte stream.
`timescale 1ns/1ps
`default_nettype none

module pcw_crc8
  import pcw_pkg::*;
#(
  parameter logic [7:0] POLY = PCW_CRC_POLY,
  parameter logic [7:0] INIT = PCW_CRC_INIT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic feed,
  input wire logic [7:0] data,
  output logic [7:0] crc
);

  // ==========================================================================
  // Next value of the remainder after one byte.
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // Clear takes priority over a byte fed in the same cycle.
  assign crc_d = clear ? INIT : (feed ? crc_step(crc_q, data) : crc_q);
  assign crc = crc_q;

  // Remainder register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= INIT;
    end else if (ce) begin
      crc_q <= crc_d;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/pcw_regs_test.sv */
// Self-checking bench for the calibration wait and NVM bookkeeping block.
// Assumes the byte register port and NVM byte streams described for pcw_regs.
`timescale 1ns/1ps
`default_nettype none

module pcw_regs_test
  import pcw_pkg::*;
;

  // ========================================
  // Shortened wait counts so the run stays brief.
  localparam int CLSD[4] = '{3, 5, 7, 9};
  localparam int OSC[4] = '{4, 6, 8, 10};
  localparam int DLY = 20;
  localparam int LIMIT = 200;

  logic clock, rst_n, ce, reg_wr, reg_rd, cal_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pg_count, stored_crc_byte;
  logic osc_cal_start, cal_busy, cal_done, crc_error_flag;
  logic nvm_rd_start, nvm_rd_end, nvm_pg_start, nvm_pg_end;
  pcw_nvm_byte_t nvm_rd_byte, nvm_pg_byte;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] cnt_q;

  pcw_regs #(.CLSD0_CYC(CLSD[0]), .CLSD1_CYC(CLSD[1]), .CLSD2_CYC(CLSD[2]),
    .CLSD3_CYC(CLSD[3]), .OSC0_CYC(OSC[0]), .OSC1_CYC(OSC[1]),
    .OSC2_CYC(OSC[2]), .OSC3_CYC(OSC[3]), .CALDLY_CYC(DLY)) dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cal_start(cal_start),
    .osc_cal_start(osc_cal_start), .cal_busy(cal_busy),
    .cal_done(cal_done), .nvm_rd_start(nvm_rd_start),
    .nvm_rd_byte(nvm_rd_byte), .nvm_rd_end(nvm_rd_end),
    .nvm_pg_start(nvm_pg_start), .nvm_pg_byte(nvm_pg_byte),
    .nvm_pg_end(nvm_pg_end), .pg_count(pg_count),
    .stored_crc_byte(stored_crc_byte), .crc_error_flag(crc_error_flag));

  // Free-running 250 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ========================================
  // Shared helpers: stepping, comparing, register cycles.
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    step();
    check(what, reg_rdata, exp);
  endtask

  // Reference CRC-8, MSB first, skipping the stored-CRC slot at index 1.
  function automatic logic [7:0] crc8(input logic [7:0] b[5]);
    logic [7:0] c;
    c = PCW_CRC_INIT;
    for (int i = 0; i < 5; i++) begin
      if (i != 1) begin
        c = c ^ b[i];
        for (int k = 0; k < 8; k++) begin
          c = c[7] ? ((c << 1) ^ PCW_CRC_POLY) : (c << 1);
        end
      end
    end
    return c;
  endfunction

  // ========================================
  // Calibration run: measures both latencies and refuses a busy restart.
  task automatic cal_run(input int dly, input int o, input int c);
    int n;
    int m;
    reg_write(PCW_OFS_CAL_WAIT, {4'h0, c[1:0], o[1:0]});
    reg_write(PCW_OFS_CAL_DELAY, {7'h00, dly[0]});
    cal_start = 1'b1;
    step();
    cal_start = 1'b0;
    check("busy after start", {7'h00, cal_busy}, 8'h01);
    n = 1;
    while (osc_cal_start !== 1'b1 && n < LIMIT) begin
      step();
      n++;
    end
    check("osc start latency", n[7:0], dly[0] ? 8'(DLY + 1) : 8'h01);
    m = 0;
    while (cal_done !== 1'b1 && m < LIMIT) begin
      if (m == 2) cal_start = 1'b1;
      if (m == 3) cal_start = 1'b0;
      step();
      m++;
    end
    check("wait length", m[7:0], 8'(OSC[o] + CLSD[c]));
    check("busy at done", {7'h00, cal_busy}, 8'h00);
    if (n >= LIMIT || m >= LIMIT) begin
      n_errors++;
      summarize();
    end
  endtask

  // Streams five bytes: index 1 is the stored CRC, index 3 the count.
  task automatic nvm_run(input bit pg, input logic [7:0] b[5],
                         input logic [7:0] exp_pc);
    pcw_nvm_byte_t v;
    if (pg) nvm_pg_start = 1'b1;
    else nvm_rd_start = 1'b1;
    step();
    if (pg) nvm_pg_start = 1'b0;
    else nvm_rd_start = 1'b0;
    for (int i = 0; i < 5; i++) begin
      v = {1'b1, i == 1, i == 3, b[i]};
      if (pg) nvm_pg_byte = v;
      else nvm_rd_byte = v;
      step();
      if (pg && i == 0) check("pg_count", pg_count, exp_pc);
    end
    nvm_pg_byte = '0;
    nvm_rd_byte = '0;
    if (pg) nvm_pg_end = 1'b1;
    else nvm_rd_end = 1'b1;
    step();
    if (pg) nvm_pg_end = 1'b0;
    else nvm_rd_end = 1'b0;
    step();
  endtask

  // Program cycle: count advances with saturation, stored CRC is computed.
  task automatic prog_chk(input logic [7:0] b0, input logic [7:0] b2);
    logic [7:0] b[5];
    logic [7:0] s;
    s = (cnt_q == 8'hFF) ? 8'hFF : cnt_q + 8'h01;
    b = '{b0, 8'hA5, b2, s, 8'h3C};
    nvm_run(1'b1, b, s);
    check("stored crc port", stored_crc_byte, crc8(b));
    rd_chk("stored crc reg", PCW_OFS_STORED_CRC, crc8(b));
    rd_chk("count after program", PCW_OFS_PROG_COUNT, s);
    cnt_q = s;
    $display("test program %h done", s);
  endtask

  // Read-back: live CRC, error flag, count and stored CRC reload.
  task automatic rb_chk(input logic [7:0] cnt, input bit bad);
    logic [7:0] b[5];
    b = '{8'h11, 8'h00, 8'h22, cnt, 8'h33};
    b[1] = crc8(b) ^ {7'h00, bad};
    nvm_run(1'b0, b, 8'h00);
    check("error port", {7'h00, crc_error_flag}, {7'h00, bad});
    rd_chk("live crc", PCW_OFS_LIVE_CRC, crc8(b));
    rd_chk("error bit", PCW_OFS_NVM_CTRL, {2'b00, bad, 5'b00000});
    rd_chk("count reload", PCW_OFS_PROG_COUNT, cnt);
    rd_chk("stored crc reload", PCW_OFS_STORED_CRC, b[1]);
    cnt_q = cnt;
    $display("test read-back bad=%0d done", bad);
  endtask

  // ========================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cal_start = 1'b0;
    nvm_rd_start = 1'b0;
    nvm_rd_end = 1'b0;
    nvm_pg_start = 1'b0;
    nvm_pg_end = 1'b0;
    nvm_rd_byte = '0;
    nvm_pg_byte = '0;
    cnt_q = 8'h00;
    repeat (5) @(posedge clock);
    #1;
    rst_n = 1'b1;
    for (int a = 8'h85; a <= 8'h8B; a++) begin
      rd_chk("reset value", 8'(a), (a == 8'h85) ? 8'h01 : 8'h00);
    end
    $display("test reset done");
    reg_write(PCW_OFS_CAL_WAIT, 8'hFF);
    rd_chk("wait reg", PCW_OFS_CAL_WAIT, 8'h0F);
    reg_write(PCW_OFS_CAL_DELAY, 8'hFF);
    rd_chk("delay reg", PCW_OFS_CAL_DELAY, 8'h01);
    reg_write(PCW_OFS_STORED_CRC, 8'hFF);
    reg_write(PCW_OFS_PROG_COUNT, 8'hFF);
    rd_chk("crc read-only", PCW_OFS_STORED_CRC, 8'h00);
    rd_chk("count read-only", PCW_OFS_PROG_COUNT, 8'h00);
    ce = 1'b0;
    reg_write(PCW_OFS_CAL_DELAY, 8'h00);
    ce = 1'b1;
    rd_chk("frozen write", PCW_OFS_CAL_DELAY, 8'h01);
    $display("test registers done");
    // every wait code, delay off and on.
    for (int d = 0; d < 2; d++) begin
      for (int o = 0; o < 4; o++) begin
        for (int c = 0; c < 4; c++) begin
          cal_run(d, o, c);
        end
      end
    end
    $display("test calibration done");
    rb_chk(8'h00, 1'b0);
    rb_chk(8'h00, 1'b1);
    prog_chk(8'h5E, 8'hC7);
    rb_chk(8'hFE, 1'b0);
    prog_chk(8'h01, 8'h80);
    prog_chk(8'hFF, 8'h00);
    // mid-run reset restores the reset values.
    rst_n = 1'b0;
    step();
    rst_n = 1'b1;
    rd_chk("wait after reset", PCW_OFS_CAL_WAIT, 8'h01);
    rd_chk("count after reset", PCW_OFS_PROG_COUNT, 8'h00);
    $display("test mid-run reset done");
    summarize();
  end
endmodule

`default_nettype wire
